// ---- adcsc_control.sv ----
// converter sequencer control: register file, conversion sequencer, pin decode
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/100ps
module adcsc_control #(
    parameter int RC_DIVIDE = adcsc_pkg::RC_DIV
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // device state
    input wire logic sleep_i,
    // analog front end
    input wire logic comp_hi_i,
    output logic core_power_o,
    output logic sample_track_o,
    output logic [2:0] channel_o,
    output logic [9:0] dac_code_o,
    // pins, references and flag
    output logic [7:0] pin_analog_o,
    output logic vref_pos_ext_o,
    output logic vref_neg_ext_o,
    output logic done_flag_o,
    output logic done_irq_en_o
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] ctrl0_r;
    logic [7:0] ctrl1_r;
    logic [7:0] res_hi_r;
    logic [7:0] res_lo_r;
    logic flag_r;
    logic irq_en_r;
    adcsc_pkg::adcsc_state_t state_r;
    logic [3:0] tad_cnt_r;
    logic [1:0] gap_cnt_r;
    logic sar_start_r;
    logic tick;
    logic rc_sel;
    logic wr_hit;
    logic wr_c0;
    logic wr_c1;
    logic wr_hi;
    logic wr_lo;
    logic wr_fl;
    logic complete;
    logic sleep_abort;
    logic sar_step;
    logic [9:0] sar_code;
    logic [15:0] just_word;
    logic [31:0] rd_word;
    adcsc_pkg::adcsc_pincfg_t pincfg;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    // writes land on the edge that raises ack; only the low byte lane carries data
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign wr_c0 = wr_hit && (wb_adr_i[7:2] == adcsc_pkg::OFS_CTRL_FIRST[7:2]);
    assign wr_c1 = wr_hit && (wb_adr_i[7:2] == adcsc_pkg::OFS_CTRL_SECOND[7:2]);
    assign wr_hi = wr_hit && (wb_adr_i[7:2] == adcsc_pkg::OFS_RESULT_HIGH[7:2]);
    assign wr_lo = wr_hit && (wb_adr_i[7:2] == adcsc_pkg::OFS_RESULT_LOW[7:2]);
    assign wr_fl = wr_hit && (wb_adr_i[7:2] == adcsc_pkg::OFS_FLAG[7:2]);

    // read mux, unmapped addresses answer zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_adr_i[7:2])
            adcsc_pkg::OFS_CTRL_FIRST[7:2]: rd_word[7:0] = ctrl0_r;
            adcsc_pkg::OFS_CTRL_SECOND[7:2]: rd_word[7:0] = ctrl1_r;
            adcsc_pkg::OFS_RESULT_HIGH[7:2]: rd_word[7:0] = res_hi_r;
            adcsc_pkg::OFS_RESULT_LOW[7:2]: rd_word[7:0] = res_lo_r;
            adcsc_pkg::OFS_FLAG[7:2]: rd_word[1:0] = {irq_en_r, flag_r};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // single-wait ack, dropped the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // reset restores control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl0_r <= adcsc_pkg::CTRL_FIRST_RST;
        end else begin
            if (wr_c0) begin
                ctrl0_r[7:3] <= wb_dat_i[7:3];
                ctrl0_r[adcsc_pkg::C0_POWER] <= wb_dat_i[adcsc_pkg::C0_POWER];
            end
            ctrl0_r[adcsc_pkg::C0_RSVD] <= 1'b0;
            if (!ctrl0_r[adcsc_pkg::C0_POWER] || complete || sleep_abort) begin
                ctrl0_r[adcsc_pkg::C0_GO] <= 1'b0;
            end else if (wr_c0) begin
                ctrl0_r[adcsc_pkg::C0_GO] <= wb_dat_i[adcsc_pkg::C0_GO];
            end
        end
    end

    // bits five and four held zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_r <= adcsc_pkg::CTRL_SECOND_RST;
        end else if (wr_c1) begin
            ctrl1_r <= {wb_dat_i[7:6], 2'h0, wb_dat_i[3:0]};
        end
    end

    // done flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_r <= 1'b0;
            irq_en_r <= 1'b0;
        end else begin
            if (complete) begin
                flag_r <= 1'b1;
            end else if (wr_fl) begin
                flag_r <= wb_dat_i[adcsc_pkg::FL_DONE];
            end
            if (wr_fl) begin
                irq_en_r <= wb_dat_i[adcsc_pkg::FL_IRQ_EN];
            end
        end
    end

    // ------------------------------------------------------------
    // result pair
    // ------------------------------------------------------------
    // justify set: right aligned, upper zeros; justify clear: left aligned, lower zeros
    assign just_word = ctrl1_r[adcsc_pkg::C1_JUSTIFY] ? {6'h00, sar_code} : {sar_code, 6'h00};

    // no reset term, content after power-up is unknown
    // hardware load beats a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (complete) begin
            res_hi_r <= just_word[15:8];
            res_lo_r <= just_word[7:0];
        end else begin
            if (wr_hi) begin
                res_hi_r <= wb_dat_i[7:0];
            end
            if (wr_lo) begin
                res_lo_r <= wb_dat_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    // clock code, high bit above low pair
    adcsc_tad_div #(
        .RC_DIVIDE(RC_DIVIDE)
    ) u_tad_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(ctrl0_r[adcsc_pkg::C0_POWER]),
        .sleep_i(sleep_i),
        .sel_i({ctrl1_r[adcsc_pkg::C1_CLK_HIGH], ctrl0_r[7:6]}),
        .tick_o(tick),
        .rc_sel_o(rc_sel)
    );

    assign complete = (state_r == adcsc_pkg::ST_CONV) && tick && ctrl0_r[adcsc_pkg::C0_GO]
                      && (tad_cnt_r == adcsc_pkg::CONV_TADS - 4'h1);
    assign sleep_abort = (state_r == adcsc_pkg::ST_CONV) && sleep_i && !rc_sel;
    assign sar_step = (state_r == adcsc_pkg::ST_CONV) && tick
                      && tad_cnt_r >= adcsc_pkg::SAR_FIRST_TAD && tad_cnt_r <= adcsc_pkg::SAR_LAST_TAD;

    adcsc_sar #(
        .WIDTH(adcsc_pkg::RES_BITS)
    ) u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(sar_start_r),
        .step_i(sar_step),
        .comp_hi_i(comp_hi_i),
        .code_o(sar_code)
    );

    // idle acquires; a go set during the gap waits for the gap to pass
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl0_r[adcsc_pkg::C0_POWER]) begin
            state_r <= adcsc_pkg::ST_IDLE;
            tad_cnt_r <= 4'h0;
            gap_cnt_r <= 2'h0;
            sar_start_r <= 1'b0;
        end else begin
            sar_start_r <= 1'b0;
            case (state_r)
                adcsc_pkg::ST_IDLE: begin
                    if (ctrl0_r[adcsc_pkg::C0_GO]) begin
                        state_r <= adcsc_pkg::ST_CONV;
                        tad_cnt_r <= 4'h0;
                        sar_start_r <= 1'b1;
                    end
                end
                adcsc_pkg::ST_CONV: begin
                    if (!ctrl0_r[adcsc_pkg::C0_GO] || complete || sleep_abort) begin
                        state_r <= adcsc_pkg::ST_GAP;
                        gap_cnt_r <= 2'h0;
                    end else if (tick) begin
                        tad_cnt_r <= tad_cnt_r + 4'h1;
                    end
                end
                adcsc_pkg::ST_GAP: begin
                    if (tick && gap_cnt_r == adcsc_pkg::GAP_TADS - 2'h1) begin
                        state_r <= adcsc_pkg::ST_IDLE;
                    end else if (tick) begin
                        gap_cnt_r <= gap_cnt_r + 2'h1;
                    end
                end
                default: state_r <= adcsc_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin configuration decode
    // ------------------------------------------------------------
    // per-pin analog mask and references
    always_comb begin
        case (ctrl1_r[3:0])
            4'h0: pincfg = '{8'hff, 1'b0, 1'b0};
            4'h1: pincfg = '{8'hff, 1'b1, 1'b0};
            4'h2: pincfg = '{8'h1f, 1'b0, 1'b0};
            4'h3: pincfg = '{8'h1f, 1'b1, 1'b0};
            4'h4: pincfg = '{8'h0b, 1'b0, 1'b0};
            4'h5: pincfg = '{8'h0b, 1'b1, 1'b0};
            4'h6: pincfg = '{8'h00, 1'b0, 1'b0};
            4'h7: pincfg = '{8'h00, 1'b0, 1'b0};
            4'h8: pincfg = '{8'hff, 1'b1, 1'b1};
            4'h9: pincfg = '{8'h3f, 1'b0, 1'b0};
            4'ha: pincfg = '{8'h3f, 1'b1, 1'b0};
            4'hb: pincfg = '{8'h3f, 1'b1, 1'b1};
            4'hc: pincfg = '{8'h1f, 1'b1, 1'b1};
            4'hd: pincfg = '{8'h0f, 1'b1, 1'b1};
            4'he: pincfg = '{8'h01, 1'b0, 1'b0};
            default: pincfg = '{8'h0d, 1'b1, 1'b1};
        endcase
    end

    // outputs from flops; the hold switch opens for the whole conversion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_analog_o <= 8'hff;
            vref_pos_ext_o <= 1'b0;
            vref_neg_ext_o <= 1'b0;
            core_power_o <= 1'b0;
            sample_track_o <= 1'b0;
            channel_o <= 3'h0;
            dac_code_o <= 10'h000;
            done_flag_o <= 1'b0;
            done_irq_en_o <= 1'b0;
        end else begin
            pin_analog_o <= pincfg.analog_mask;
            vref_pos_ext_o <= pincfg.vref_pos_ext;
            vref_neg_ext_o <= pincfg.vref_neg_ext;
            core_power_o <= ctrl0_r[adcsc_pkg::C0_POWER];
            sample_track_o <= ctrl0_r[adcsc_pkg::C0_POWER] && state_r == adcsc_pkg::ST_IDLE;
            channel_o <= ctrl0_r[5:3];
            dac_code_o <= sar_code;
            done_flag_o <= flag_r;
            done_irq_en_o <= irq_en_r;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [3:0] conv_ticks_r;
    logic [1:0] gap_ticks_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || state_r != adcsc_pkg::ST_CONV) begin
            conv_ticks_r <= 4'h0;
        end else if (tick && conv_ticks_r != 4'hf) begin
            conv_ticks_r <= conv_ticks_r + 4'h1;
        end
        if (rst_i || state_r != adcsc_pkg::ST_GAP) begin
            gap_ticks_r <= 2'h0;
        end else if (tick && gap_ticks_r != 2'h3) begin
            gap_ticks_r <= gap_ticks_r + 2'h1;
        end
    end

    sequence s_done;
        complete;
    endsequence

    a_go_self_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        s_done |=> !ctrl0_r[adcsc_pkg::C0_GO] && state_r == adcsc_pkg::ST_GAP)
        else $error("go bit not cleared at completion");
    a_power_off_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl0_r[adcsc_pkg::C0_POWER] |=> state_r == adcsc_pkg::ST_IDLE && !core_power_o)
        else $error("converter active while powered off");
    a_rsvd_first_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && wb_adr_i == adcsc_pkg::OFS_CTRL_FIRST |-> wb_dat_o[adcsc_pkg::C0_RSVD] == 1'b0)
        else $error("reserved bit one reads nonzero");
    a_rsvd_second_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && wb_adr_i == adcsc_pkg::OFS_CTRL_SECOND |-> wb_dat_o[5:4] == 2'h0)
        else $error("reserved bits five and four read nonzero");
    a_right_justify: assert property (@(posedge clk_i) disable iff (rst_i)
        s_done and ctrl1_r[adcsc_pkg::C1_JUSTIFY] |=> res_hi_r[7:2] == 6'h00 && res_lo_r == sar_code[7:0])
        else $error("right justified result wrong");
    a_left_justify: assert property (@(posedge clk_i) disable iff (rst_i)
        s_done and !ctrl1_r[adcsc_pkg::C1_JUSTIFY] |=> res_lo_r[5:0] == 6'h00 && res_hi_r == sar_code[9:2])
        else $error("left justified result wrong");
    a_reset_pins_analog: assert property (@(posedge clk_i)
        rst_i |=> pin_analog_o == 8'hff && !core_power_o)
        else $error("pins not analog after reset");
    a_reset_abort: assert property (@(posedge clk_i)
        rst_i |=> state_r == adcsc_pkg::ST_IDLE && ctrl0_r == adcsc_pkg::CTRL_FIRST_RST)
        else $error("reset did not abort conversion");
    a_flag_on_done: assert property (@(posedge clk_i) disable iff (rst_i)
        s_done |=> flag_r ##1 done_flag_o)
        else $error("done flag not set at completion");
    a_conv_twelve: assert property (@(posedge clk_i) disable iff (rst_i)
        s_done |-> conv_ticks_r == adcsc_pkg::CONV_TADS - 4'h1)
        else $error("conversion length is not twelve periods");
    a_gap_two: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == adcsc_pkg::ST_GAP ##1 state_r == adcsc_pkg::ST_IDLE |-> $past(gap_ticks_r) == 2'h1 && $past(tick))
        else $error("gap shorter than two periods");
    a_sleep_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == adcsc_pkg::ST_CONV && sleep_i && !rc_sel |=> state_r != adcsc_pkg::ST_CONV && !complete)
        else $error("oscillator conversion ran in sleep");
endmodule

// ---- adcsc_pkg.sv ----
// shared constants, types and register map of the converter sequencer control
package adcsc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the wishbone bus)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_FIRST = 8'h00;
    localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h08;
    localparam logic [7:0] OFS_RESULT_LOW = 8'h0c;
    localparam logic [7:0] OFS_FLAG = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int C0_POWER = 0;
    localparam int C0_RSVD = 1;
    localparam int C0_GO = 2;
    localparam int C0_CHAN_LSB = 3;
    localparam int C0_CLK_LSB = 6;
    localparam int C1_PCFG_LSB = 0;
    localparam int C1_RSVD_LSB = 4;
    localparam int C1_CLK_HIGH = 6;
    localparam int C1_JUSTIFY = 7;
    localparam int FL_DONE = 0;
    localparam int FL_IRQ_EN = 1;

    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_FIRST_RST = 8'h00;
    localparam logic [7:0] CTRL_SECOND_RST = 8'h00;
    localparam logic [1:0] CLK_LOW_RC = 2'h3;
    localparam logic [3:0] PCFG_ALL_ANALOG = 4'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int RES_BITS = 10;
    localparam logic [3:0] CONV_TADS = 4'hc;
    localparam logic [3:0] SAR_FIRST_TAD = 4'h1;
    localparam logic [3:0] SAR_LAST_TAD = 4'ha;
    localparam logic [1:0] GAP_TADS = 2'h2;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RC_PERIOD_NS = 4000;
    localparam int RC_DIV = (RC_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] analog_mask;
        logic vref_pos_ext;
        logic vref_neg_ext;
    } adcsc_pincfg_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_GAP = 3'b100
    } adcsc_state_t;

endpackage

// ---- adcsc_tad_div.sv ----
// conversion bit-period enable generator, oscillator divider or internal rc
`timescale 1ns/100ps
module adcsc_tad_div #(
    parameter int RC_DIVIDE = adcsc_pkg::RC_DIV
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic run_i,
    input wire logic sleep_i,
    input wire logic [2:0] sel_i,
    // enable pulse and rc source select
    output logic tick_o,
    output logic rc_sel_o
);
    logic [5:0] osc_cnt_r;
    logic [15:0] rc_cnt_r;
    logic [5:0] osc_last;
    logic rc_sel;

    // divide ratio minus one from the three-bit code
    always_comb begin
        case (sel_i)
            3'h0: osc_last = 6'h01;
            3'h1: osc_last = 6'h07;
            3'h2: osc_last = 6'h1f;
            3'h4: osc_last = 6'h03;
            3'h5: osc_last = 6'h0f;
            3'h6: osc_last = 6'h3f;
            default: osc_last = 6'h3f;
        endcase
    end
    assign rc_sel = (sel_i[1:0] == adcsc_pkg::CLK_LOW_RC);

    // oscillator divider stops in sleep, the rc source keeps running
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || rc_sel || sleep_i) begin
            osc_cnt_r <= 6'h00;
        end else if (osc_cnt_r >= osc_last) begin
            osc_cnt_r <= 6'h00;
        end else begin
            osc_cnt_r <= osc_cnt_r + 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || !rc_sel) begin
            rc_cnt_r <= 16'h0000;
        end else if (rc_cnt_r >= 16'(RC_DIVIDE - 1)) begin
            rc_cnt_r <= 16'h0000;
        end else begin
            rc_cnt_r <= rc_cnt_r + 16'h0001;
        end
    end

    // registered pulse, one clock wide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
            rc_sel_o <= 1'b0;
        end else begin
            tick_o <= run_i && (rc_sel ? (rc_cnt_r >= 16'(RC_DIVIDE - 1))
                                       : (!sleep_i && osc_cnt_r >= osc_last));
            rc_sel_o <= rc_sel;
        end
    end
endmodule

// ---- adcsc_sar.sv ----
// successive approximation register, one bit decided per step
`timescale 1ns/100ps
module adcsc_sar #(
    parameter int WIDTH = adcsc_pkg::RES_BITS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // sequencing
    input wire logic start_i,
    input wire logic step_i,
    input wire logic comp_hi_i,
    // trial code to the dac and final value
    output logic [WIDTH-1:0] code_o
);
    logic [WIDTH-1:0] probe_r;

    // keep the trial bit when the input is above the dac, then try the next one down
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_o <= '0;
            probe_r <= '0;
        end else if (start_i) begin
            probe_r <= {1'b1, {(WIDTH-1){1'b0}}};
            code_o <= {1'b1, {(WIDTH-1){1'b0}}};
        end else if (step_i && probe_r != '0) begin
            probe_r <= probe_r >> 1;
            code_o <= (comp_hi_i ? code_o : (code_o & ~probe_r)) | (probe_r >> 1);
        end
    end
endmodule

// ---- adcsc_control_bench.sv ----
// self-checking bench for the converter sequencer control
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t %h %h", $time, a, b); end end
module adcsc_control_bench;
    // ------------------------------------------------------------
    // signals, clock and front end
    // ------------------------------------------------------------
    localparam logic [7:0] A0 = adcsc_pkg::OFS_CTRL_FIRST;
    localparam logic [7:0] A1 = adcsc_pkg::OFS_CTRL_SECOND;
    localparam logic [7:0] AH = adcsc_pkg::OFS_RESULT_HIGH;
    localparam logic [7:0] AL = adcsc_pkg::OFS_RESULT_LOW;
    localparam logic [7:0] AF = adcsc_pkg::OFS_FLAG;
    // expected {analog mask, positive ref, negative ref} per port code
    localparam logic [9:0] PC [16] = '{10'h3fc, 10'h3fe, 10'h07c, 10'h07e, 10'h02c, 10'h02e, 10'h000, 10'h000,
        10'h3ff, 10'h0fc, 10'h0fe, 10'h0ff, 10'h07f, 10'h03f, 10'h004, 10'h037};
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0, comp = 1'b0;
    logic [7:0] adr = 8'h00, q;
    logic [31:0] dat = 32'h0, rdat;
    logic ack, pwr, trk, vp, vn, dflag, den;
    logic [2:0] chan;
    logic [9:0] dac, vin = 10'h25a;
    logic [7:0] pins;
    int bad_count = 0, compares = 0;
    always #2.5 clk_i = ~clk_i;
    // comparator model, one cycle of settling after each trial code
    always @(posedge clk_i) begin
        comp <= (vin >= dac);
    end
    adcsc_control #(.RC_DIVIDE(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sleep_i(slp), .comp_hi_i(comp), .core_power_o(pwr), .sample_track_o(trk), .channel_o(chan),
        .dac_code_o(dac), .pin_analog_o(pins), .vref_pos_ext_o(vp), .vref_neg_ext_o(vn),
        .done_flag_o(dflag), .done_irq_en_o(den));
    // ------------------------------------------------------------
    // bus tasks and closing
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one classic cycle; request held until ack is seen, released at that edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
        @(posedge clk_i);
        // ack and read data are taken at the rising edge that sees ack high
        while (ack !== 1'b1) begin
            n++;
            if (n > 40) begin
                bad_count++;
                complete_run();
            end
            @(posedge clk_i);
        end
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rchk(A0, 8'h00);
        rchk(A1, 8'h00);
        rchk(AF, 8'h00);
        rchk(8'h20, 8'h00);
        `CHK(pins, 8'hff)
        `CHK(pwr, 1'b0)
        $display("reset values done");
    endtask
    // go with power off must be dropped, reserved bits stay low
    task automatic t_ctrl;
        bus(1'b1, A0, 8'h3e);
        rchk(A0, 8'h38);
        `CHK(chan, 3'h7)
        `CHK(pwr, 1'b0)
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, A1, 8'hf0 | 8'(i));
            rchk(A1, 8'hc0 | 8'(i));
            `CHK({pins, vp, vn}, PC[i])
        end
        bus(1'b1, A1, 8'h00);
        $display("control fields done");
    endtask
    // configure, power, clear flag, then start and poll
    task automatic t_conv(input logic j, input logic [7:0] c, input logic s, input logic [7:0] h, l);
        int n;
        n = 0;
        bus(1'b1, A1, {j, 7'h00});
        bus(1'b1, A0, c);
        @(negedge clk_i);
        `CHK(pwr, 1'b1)
        bus(1'b1, AF, 8'h00);
        slp <= s;
        repeat (8) @(posedge clk_i);
        bus(1'b1, A0, c | 8'h04);
        do begin
            bus(1'b0, A0, 8'h00);
            n++;
        end while (q[2] === 1'b1 && n < 300);
        `CHK(q, c)
        rchk(AF, 8'h01);
        rchk(AH, h);
        rchk(AL, l);
        slp <= 1'b0;
        $display("conversion done");
    endtask
    // a cleared go mid-way must leave the old result and no flag
    task automatic t_abort;
        vin <= 10'h0f0;
        bus(1'b1, AF, 8'h02);
        bus(1'b1, A0, 8'h85);
        repeat (20) @(posedge clk_i);
        bus(1'b1, A0, 8'h81);
        repeat (100) @(posedge clk_i);
        `CHK(trk, 1'b1)
        `CHK(den, 1'b1)
        `CHK(dflag, 1'b0)
        rchk(A0, 8'h81);
        rchk(AF, 8'h02);
        rchk(AH, 8'h96);
        rchk(AL, 8'h80);
        $display("abort done");
    endtask
    task automatic t_rst;
        bus(1'b1, A1, 8'h06);
        bus(1'b1, A0, 8'h85);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(A0, 8'h00);
        `CHK(pins, 8'hff)
        rchk(AH, 8'h96);
        $display("mid-run reset done");
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_ctrl();
        t_conv(1'b1, 8'h81, 1'b0, 8'h02, 8'h5a);
        t_conv(1'b0, 8'hc1, 1'b1, 8'h96, 8'h80);
        t_abort();
        t_rst();
        complete_run();
    end
endmodule
